//--- common/i2c_slave_pkg.sv
// Purpose: Shared constants for the two-wire register slave
// Assumes: Sampled on a 200 MHz reference clock
// Notes:   Register contents live in the top module
package i2c_slave_pkg;
  localparam int unsigned   ADDR_W          = 7;
  localparam logic [6:0]    SLAVE_ADDR_LOW  = 7'h20;
  localparam logic [6:0]    SLAVE_ADDR_HIGH = 7'h24;
  localparam int unsigned   DATA_W          = 8;
  localparam int unsigned   REG_COUNT       = 256;
  localparam logic [7:0]    REG_RESET       = 8'h00;
  localparam logic [7:0]    PTR_RESET       = 8'h00;
  localparam logic [7:0]    PTR_STEP        = 8'h01;
  localparam logic [3:0]    BIT_LAST        = 4'h7;
  localparam logic [3:0]    BIT_ZERO        = 4'h0;
  localparam int unsigned   CLK_PERIOD_PS   = 5000;
  localparam int unsigned   SYNC_STAGES     = 2;

  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_ADDR = 6'b000010,
    ST_AACK = 6'b000100,
    ST_RX   = 6'b001000,
    ST_TX   = 6'b010000,
    ST_MACK = 6'b100000
  } slave_state_type;
endpackage

//--- common/line_sample_if.sv
// Purpose: Carries synchronised bus levels and their edges
// Assumes: One clock domain
// Notes:   Driven by the line sampler, read by the top
`timescale 1ns/1ps
interface line_sample_if;
  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  modport source (output scl, sda, scl_rise, scl_fall, start_seen, stop_seen);
  modport sink   (input  scl, sda, scl_rise, scl_fall, start_seen, stop_seen);
endinterface

//--- logic/line_sampler.sv
// Purpose: Two-flop synchronisers and edge/condition detection for SCL and SDA
// Assumes: Pins are asynchronous to i_ref_clk
// Notes:   First flop of each chain feeds only the second
`timescale 1ns/1ps
module line_sampler (
  input  wire logic          i_ref_clk,
  input  wire logic          i_arst_n,
  input  wire logic          i_scl,
  input  wire logic          i_sda,
  line_sample_if.source      lines
);
  logic scl_meta;
  logic sda_meta;
  logic scl_sync;
  logic sda_sync;
  logic scl_prev;
  logic sda_prev;

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      scl_meta <= 1'b1;
      sda_meta <= 1'b1;
      scl_sync <= 1'b1;
      sda_sync <= 1'b1;
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end else begin
      scl_meta <= i_scl;
      sda_meta <= i_sda;
      scl_sync <= scl_meta;
      sda_sync <= sda_meta;
      scl_prev <= scl_sync;
      sda_prev <= sda_sync;
    end
  end

  assign lines.scl        = scl_sync;
  assign lines.sda        = sda_sync;
  assign lines.scl_rise   = scl_sync & ~scl_prev;
  assign lines.scl_fall   = ~scl_sync & scl_prev;
  // Data moves only while clock is high for a condition
  assign lines.start_seen = scl_sync & scl_prev & sda_prev & ~sda_sync;
  assign lines.stop_seen  = scl_sync & scl_prev & ~sda_prev & sda_sync;
endmodule

//--- logic/i2c_slave_register_access.sv
// Purpose: Two-wire slave giving a master access to a byte register file
// Assumes: Master drives SCL; both lines pulled up outside
// Notes:   SDA is open drain: only a low is ever driven
`timescale 1ns/1ps
import i2c_slave_pkg::*;

// Function
// - Slave only; master starts transfers, drives clock
// - SDA open-drain low only; SCL input
// - Select pin picks address 0x20 or 0x24
// - Fixed-address variant answers 0x20 only
// - Both lines high while bus idle
// - Start: SDA falls while SCL high
// - Stop: SDA rises while SCL high
// - One bit per clock, stable while high
// - First written byte is pointer, rest data
// - First data byte goes to pointed register
// - Later data bytes go to next registers
// - Pointer advances after every data byte
// - Reads use retained pointer, then advance
// - First read byte from pointer at start
module i2c_slave_register_access #(
  parameter bit HAS_ADDR_SELECT = 1'b1
) (
  input  wire logic                          i_ref_clk,
  input  wire logic                          i_arst_n,
  input  wire logic                          i_scl,
  input  wire logic                          i_sda,
  input  wire logic                          i_slave_addr_select_pin,
  output logic                               o_sda,
  output logic                               o_sda_oe,
  output logic [i2c_slave_pkg::DATA_W-1:0]   o_reg_ptr,
  output logic                               o_busy
);
  import i2c_slave_pkg::*;

  line_sample_if lines ();

  slave_state_type     state;
  slave_state_type     next_state;
  logic [DATA_W-1:0]   shift;
  logic [3:0]          bit_cnt;
  logic [DATA_W-1:0]   ptr;
  logic                ptr_loaded;
  logic                is_read;
  logic                sda_low;
  logic                sel_meta;
  logic                sel_sync;
  logic [DATA_W-1:0]   regs [REG_COUNT];

  line_sampler u_line_sampler (
    .i_ref_clk (i_ref_clk),
    .i_arst_n  (i_arst_n),
    .i_scl     (i_scl),
    .i_sda     (i_sda),
    .lines     (lines)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Address select pin is static but still crosses into this domain
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sel_meta <= 1'b0;
      sel_sync <= 1'b0;
    end else begin
      sel_meta <= i_slave_addr_select_pin;
      sel_sync <= sel_meta;
    end
  end

  wire        use_high   = HAS_ADDR_SELECT & sel_sync;
  wire [6:0]  own_addr   = use_high ? SLAVE_ADDR_HIGH : SLAVE_ADDR_LOW;
  wire [7:0]  rx_byte    = {shift[6:0], lines.sda};
  wire        addr_match = (rx_byte[7:1] == own_addr);
  wire        byte_done  = lines.scl_rise && (bit_cnt == BIT_LAST);
  wire        bit_done   = lines.scl_rise && (bit_cnt != BIT_LAST);
  wire [7:0]  ptr_next   = 8'(ptr + PTR_STEP);
  wire [7:0]  tx_byte    = regs[ptr];
  wire        wr_data    = (state == ST_RX) && byte_done && ptr_loaded;
  wire        wr_ptr     = (state == ST_RX) && byte_done && !ptr_loaded;
  wire        rd_step    = (state == ST_TX) && byte_done;

  ////////////////////////////////////////////////////////////////////////////
  // Bit sequencing; the clock is only ever observed, never driven
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: next_state = ST_IDLE;
      ST_ADDR: begin
        if (byte_done) begin
          next_state = addr_match ? ST_AACK : ST_IDLE;
        end
      end
      ST_AACK: begin
        if (lines.scl_fall && sda_low) begin
          next_state = is_read ? ST_TX : ST_RX;
        end
      end
      ST_RX: begin
        if (byte_done) begin
          next_state = ST_AACK;
        end
      end
      ST_TX: begin
        if (byte_done) begin
          next_state = ST_MACK;
        end
      end
      ST_MACK: begin
        if (lines.scl_rise) begin
          next_state = lines.sda ? ST_IDLE : ST_TX;
        end
      end
      default: next_state = ST_IDLE;
    endcase
    // Start, also repeated, restarts address phase; stop frees the bus
    if (lines.start_seen) begin
      next_state = ST_ADDR;
    end else if (lines.stop_seen) begin
      next_state = ST_IDLE;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bits are taken on the SCL rise, where the master holds them steady
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      shift   <= REG_RESET;
      bit_cnt <= BIT_ZERO;
    end else if (lines.start_seen || (state == ST_AACK) || (state == ST_MACK)) begin
      bit_cnt <= BIT_ZERO;
    end else if (bit_done) begin
      shift   <= rx_byte;
      bit_cnt <= bit_cnt + 4'h1;
    end else if (byte_done) begin
      shift   <= rx_byte;
      bit_cnt <= BIT_ZERO;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      is_read    <= 1'b0;
      ptr_loaded <= 1'b0;
    end else if (lines.start_seen) begin
      ptr_loaded <= 1'b0;
    end else if ((state == ST_ADDR) && byte_done) begin
      is_read    <= rx_byte[0];
    end else if (wr_ptr) begin
      ptr_loaded <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pointer survives stop and repeated start; only reset clears it
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ptr <= PTR_RESET;
    end else if (wr_ptr) begin
      ptr <= rx_byte;
    end else if (wr_data || rd_step) begin
      ptr <= ptr_next;
    end
  end

  // Register file has no reset: the array is too large for reset flops
  always_ff @(posedge i_ref_clk) begin
    if (wr_data) begin
      regs[ptr] <= rx_byte;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // SDA changes only after an SCL fall, so it is steady while SCL is high
  // First fall in the ack state opens the ack bit, the second one closes it
  wire ack_start = (state == ST_AACK) && !sda_low;
  wire tx_phase  = (next_state == ST_TX);
  wire [3:0] tx_idx = (state == ST_TX) ? bit_cnt : BIT_ZERO;
  wire tx_bit    = tx_byte[3'(BIT_LAST - tx_idx)];

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sda_low <= 1'b0;
    end else if (lines.start_seen || lines.stop_seen) begin
      sda_low <= 1'b0;
    end else if (lines.scl_fall) begin
      if (ack_start) begin
        sda_low <= 1'b1;
      end else if (tx_phase) begin
        sda_low <= ~tx_bit;
      end else begin
        sda_low <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_sda     <= 1'b0;
      o_sda_oe  <= 1'b0;
      o_reg_ptr <= PTR_RESET;
      o_busy    <= 1'b0;
    end else begin
      o_sda     <= 1'b0;
      o_sda_oe  <= next_sda_low();
      o_reg_ptr <= ptr;
      o_busy    <= (state != ST_IDLE);
    end
  end

  function automatic logic next_sda_low();
    next_sda_low = sda_low;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  sequence s_addr_ack;
    (state == ST_AACK) && lines.scl_fall && sda_low;
  endsequence

  property p_addr_gate;
    @(posedge i_ref_clk) disable iff (!i_arst_n)
      ((state == ST_ADDR) && byte_done && !addr_match) |=> (state == ST_IDLE);
  endproperty
  a_addr_gate: assert property (p_addr_gate) else $error("ack state on foreign address");

  property p_stop_idle;
    @(posedge i_ref_clk) disable iff (!i_arst_n)
      (lines.stop_seen && !lines.start_seen) |=> (state == ST_IDLE) ##2 !o_sda_oe;
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("busy after stop");

  property p_start_addr;
    @(posedge i_ref_clk) disable iff (!i_arst_n)
      lines.start_seen |=> (state == ST_ADDR) && (bit_cnt == BIT_ZERO);
  endproperty
  a_start_addr: assert property (p_start_addr) else $error("start not taken");

  property p_only_low;
    @(posedge i_ref_clk) disable iff (!i_arst_n)
      o_sda_oe |-> !o_sda;
  endproperty
  a_only_low: assert property (p_only_low) else $error("sda driven high");

  property p_stable_high;
    @(posedge i_ref_clk) disable iff (!i_arst_n)
      (lines.scl && $past(lines.scl) && !lines.start_seen && !lines.stop_seen)
        |-> $stable(sda_low);
  endproperty
  a_stable_high: assert property (p_stable_high) else $error("sda moved with scl high");

  property p_ptr_load;
    @(posedge i_ref_clk) disable iff (!i_arst_n)
      wr_ptr |=> (ptr == $past(rx_byte)) && ptr_loaded;
  endproperty
  a_ptr_load: assert property (p_ptr_load) else $error("pointer byte not loaded");

  property p_ptr_step;
    @(posedge i_ref_clk) disable iff (!i_arst_n)
      (wr_data || rd_step) |=> (ptr == $past(ptr) + PTR_STEP);
  endproperty
  a_ptr_step: assert property (p_ptr_step) else $error("pointer did not advance");

  property p_ptr_keep;
    @(posedge i_ref_clk) disable iff (!i_arst_n)
      lines.stop_seen |=> $stable(ptr);
  endproperty
  a_ptr_keep: assert property (p_ptr_keep) else $error("pointer lost on stop");

  property p_ack_release;
    @(posedge i_ref_clk) disable iff (!i_arst_n)
      s_addr_ack |=> !sda_low || (state == ST_TX);
  endproperty
  a_ack_release: assert property (p_ack_release) else $error("ack held too long");
endmodule

//--- tb/i2c_master_model.sv
// Purpose: Bus master that bit-bangs the two-wire link
// Assumes: Bus pulled up; a 1 here releases the data line
// Notes:   160 ns bit period, four 40 ns quarters
`timescale 1ns/1ps
module i2c_master_model (
  input  wire logic i_clk,
  input  wire logic i_sda_line,
  output logic      o_scl,
  output logic      o_sda
);
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end

  task automatic q();
    repeat (8) @(posedge i_clk);
  endtask

  // Also serves as repeated start when called with the clock low
  task automatic start();
    o_sda <= 1'b1;
    q();
    o_scl <= 1'b1;
    q();
    o_sda <= 1'b0;
    q();
    o_scl <= 1'b0;
    q();
  endtask

  task automatic stop();
    o_sda <= 1'b0;
    q();
    o_scl <= 1'b1;
    q();
    o_sda <= 1'b1;
    q();
  endtask

  // Data changes only while the clock is low
  task automatic bit_x(input logic b, output logic r);
    o_sda <= b;
    q();
    o_scl <= 1'b1;
    q();
    r = i_sda_line;
    q();
    o_scl <= 1'b0;
    q();
  endtask

  // Sends 8 bits MSB first plus the ack slot; 8'hFF releases for reads
  task automatic xfer(input logic [7:0] tx, input logic ack_in,
                      output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_x(tx[i], rx[i]);
    end
    bit_x(ack_in, ack);
  endtask
endmodule

//--- tb/tb_i2c_slave_register_access.sv
// Purpose: Self-checking bench for the two-wire register slave
// Assumes: Select-pin variant, pull-up on the data wire
// Notes:   Pointer writes then reads, bursts with wrap, address select
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin bad_count++; \
  $display("BAD %s exp %h got %h", nm, ex, got); end end
module tb_i2c_slave_register_access;
  import i2c_slave_pkg::*;
  logic       ref_clk = 1'b0;
  logic       arst_n  = 1'b0;
  logic       sel     = 1'b0;
  logic       m_scl;
  logic       m_sda;
  logic       oe;
  logic       sdo;
  logic       busy;
  logic [7:0] ptr;
  wire logic  sda_line;
  int         bad_count    = 0;
  int         total_checks = 0;

  always #2.5 ref_clk = ~ref_clk;
  // Wired-AND of both parties with the pull-up
  assign sda_line = m_sda & ~(oe & ~sdo);

  i2c_slave_register_access #(.HAS_ADDR_SELECT(1'b1)) i_i2c_slave_register_access (
    .i_ref_clk(ref_clk), .i_arst_n(arst_n), .i_scl(m_scl), .i_sda(sda_line),
    .i_slave_addr_select_pin(sel), .o_sda(sdo), .o_sda_oe(oe), .o_reg_ptr(ptr),
    .o_busy(busy));
  i2c_master_model i_i2c_master_model (
    .i_clk(ref_clk), .i_sda_line(sda_line), .o_scl(m_scl), .o_sda(m_sda));

  //////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic wb(input logic [7:0] b, input logic ex_ack);
    logic [7:0] r;
    logic       a;
    i_i2c_master_model.xfer(b, 1'b1, r, a);
    `CHK("ack", ex_ack, a)
  endtask

  task automatic rb(input logic [7:0] ex, input logic more);
    logic [7:0] r;
    logic       a;
    i_i2c_master_model.xfer(8'hFF, ~more, r, a);
    `CHK("rdata", ex, r)
  endtask

  //////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    `CHK("oe", 1'b0, oe)
    `CHK("ptr", PTR_RESET, ptr)
    `CHK("busy", 1'b0, busy)
  endtask

  // Burst crosses the top of the pointer range
  task automatic t_write_burst();
    i_i2c_master_model.start();
    wb(8'h40, 1'b0);
    wb(8'hFE, 1'b0);
    wb(8'hA5, 1'b0);
    wb(8'h5A, 1'b0);
    wb(8'h3C, 1'b0);
    `CHK("ptr", 8'h01, ptr)
    i_i2c_master_model.stop();
    `CHK("busy", 1'b0, busy)
    `CHK("ptr", 8'h01, ptr)
  endtask

  task automatic t_read_back();
    i_i2c_master_model.start();
    wb(8'h40, 1'b0);
    wb(8'hFE, 1'b0);
    i_i2c_master_model.start();
    wb(8'h41, 1'b0);
    rb(8'hA5, 1'b1);
    rb(8'h5A, 1'b1);
    rb(8'h3C, 1'b0);
    i_i2c_master_model.stop();
    `CHK("ptr", 8'h01, ptr)
    `CHK("sdo", 1'b0, sdo)
  endtask

  task automatic t_retained();
    i_i2c_master_model.start();
    wb(8'h40, 1'b0);
    wb(8'hFF, 1'b0);
    i_i2c_master_model.stop();
    i_i2c_master_model.start();
    wb(8'h41, 1'b0);
    rb(8'h5A, 1'b0);
    i_i2c_master_model.stop();
    `CHK("ptr", 8'h00, ptr)
  endtask

  task automatic t_addr_select();
    i_i2c_master_model.start();
    wb(8'h48, 1'b1);
    i_i2c_master_model.stop();
    `CHK("busy", 1'b0, busy)
    @(posedge ref_clk) sel <= 1'b1;
    repeat (6) @(posedge ref_clk);
    i_i2c_master_model.start();
    wb(8'h40, 1'b1);
    i_i2c_master_model.stop();
    i_i2c_master_model.start();
    wb(8'h48, 1'b0);
    wb(8'h10, 1'b0);
    i_i2c_master_model.stop();
    `CHK("ptr", 8'h10, ptr)
    @(posedge ref_clk) sel <= 1'b0;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (6) @(posedge ref_clk);
    t_reset();
    t_write_burst();
    t_read_back();
    t_retained();
    t_addr_select();
    print_verdict();
  end

  // Run needs about 6k cycles; allow generous margin
  initial begin
    repeat (40000) @(posedge ref_clk);
    bad_count++;
    print_verdict();
  end
endmodule
